//--- logic/ussu_cfg.svh
`ifndef USSU_CFG_SVH
`define USSU_CFG_SVH

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define USSU_DATA_W      8
`define USSU_CNT_W       4
`define USSU_MSB         7
`define USSU_SREG_RST    8'h00
`define USSU_CNT_RST     4'h0
`define USSU_CNT_ONE     4'h1
`define USSU_CNT_MAX     4'hF

// ****************************************************************
// Wire modes
// ****************************************************************
`define USSU_WM_OFF      2'h0
`define USSU_WM_THREE    2'h1
`define USSU_WM_TWO      2'h2
`define USSU_WM_TWO_HOLD 2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define USSU_CLK_NS      25
`define USSU_SCK_DIV     4
`define USSU_SCK_MIN_NS  (`USSU_CLK_NS * `USSU_SCK_DIV)

`endif

//--- logic/ussu_pkg.sv
package ussu_pkg;

  typedef enum logic [1:0] {
    USSU_HOLD_IDLE  = 2'b00,
    USSU_HOLD_ARMED = 2'b01,
    USSU_HOLD_LOW   = 2'b10
  } ussu_hold_e;

  typedef struct packed {
    logic [1:0] wire_mode;
    logic       clock_source_external;
    logic       ext_clock_edge_select;
    logic       clock_strobe_select;
    logic       ovf_enable;
    logic       start_enable;
    logic       data_dir;
    logic       clock_dir;
    logic       port_data;
  } ussu_cfg_s;

  typedef struct packed {
    logic       data_write;
    logic [7:0] data_wdata;
    logic       counter_write;
    logic [3:0] counter_wdata;
    logic       ovf_clear;
    logic       start_clear;
    logic       clock_toggle_strobe;
    logic       soft_clock_strobe;
    logic       timer_match;
  } ussu_wr_s;

  typedef struct packed {
    logic [7:0] serial_shift_register;
    logic [3:0] counter_value;
    logic       count_overflow_flag;
    logic       start_detect_flag;
    logic       ovf_wake;
    logic       start_irq;
  } ussu_stat_s;

endpackage

//--- logic/ussu_top.sv
`timescale 1ns/1ps
`include "ussu_cfg.svh"
// Functional notes
// RQ1: Edge select clear: sample input on rising clock, change output on falling.
// RQ2: Edge select set: sample on falling clock edge, change output on rising.
// RQ3: Each serial clock period moves one bit into the shared shift register.
// RQ4: Both sides present output half a period before the first sampling edge.
// RQ5: External clock: counter advances on every edge, rising and falling.
// RQ6: Sixteen edges from zero overflow the counter and set the overflow flag.
// RQ7: Enabled overflow flag wakes the processor from idle sleep.
// RQ8: Master makes each bit from a sampling edge then an output-change edge.
// RQ9: Fastest supported serial clock is one quarter of the core clock.
// RQ10: External source with strobe select: toggle strobe inverts pin, advances counter.
// RQ11: Two-wire mode has no slew limiting on outputs, no input glitch filtering.
// RQ12: Master clocks by software, only slave holds clock, both shift automatically.
// RQ13: In two-wire mode only falling-edge output change is usable.
// RQ14: Master checks the clock line really rose after releasing it.
// RQ15: Slave sets start flag when data falls while clock high; may interrupt.
// RQ16: Master starts by clearing shift MSB or port bit; direction bit enables drive.
// RQ17: After start, slave holds clock low once pulled low, until flag cleared.
// RQ18: Two-wire slave captures each data bit on the rising clock edge.
// RQ19: Eight address bits overflow the counter and force clock low.
// RQ20: Addressed slave acknowledges; software presets counter to 14 first.
// RQ21: Direction bit one means master read; later bytes keep direction.
// RQ22: Slave that cannot take more data withholds the last acknowledge.
// RQ23: Writing one to overflow flag clears it and releases overflow clock hold.
// RQ24: Writing one to start flag clears it and releases start clock hold.
// RQ25: Output comes from MSB through latch open first half or always internally.

module ussu_top #(
  parameter int DATA_W = `USSU_DATA_W,
  parameter int CNT_W  = `USSU_CNT_W
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               start_line_clk,
  input  wire ussu_pkg::ussu_cfg_s  cfg,
  input  wire ussu_pkg::ussu_wr_s   wr,
  input  wire logic               serial_clock_pin,
  input  wire logic               serial_data_in,
  output logic                    serial_clock_out,
  output logic                    serial_clock_oe,
  output logic                    data_out,
  output logic                    data_oe,
  output ussu_pkg::ussu_stat_s    stat
);
  import ussu_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Structs carry fixed widths, so other sizes cannot be served
  if (DATA_W != `USSU_DATA_W) begin : g_bad_data_w
    $error("DATA_W must match the shift register width");
  end
  if (CNT_W != `USSU_CNT_W) begin : g_bad_cnt_w
    $error("CNT_W must match the edge counter width");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0] sck_sync;
    logic [1:0] din_sync;
    logic [2:0] tgl_sync;
    logic       sck_prev;
    logic [2:0] sck_warm;
    logic [7:0] sreg;
    logic [3:0] cnt;
    logic       ovf_flag;
    logic       start_flag;
    logic       latch_open;
    logic       do_latch;
    logic       sck_port;
    ussu_hold_e hold_st;
    logic       ovf_wake;
    logic       start_irq;
    logic       sck_oe_reg;
    logic       sck_out_reg;
    logic       do_out_reg;
    logic       do_oe_reg;
  } ussu_state_s;

  typedef struct packed {
    logic start_tgl;
  } ussu_link_s;

  ussu_state_s s_reg;
  ussu_state_s s_next;
  ussu_link_s  l_reg;
  ussu_link_s  l_next;

  function automatic logic is_two_wire(input logic [1:0] wm);
    is_two_wire = (wm == `USSU_WM_TWO) || (wm == `USSU_WM_TWO_HOLD);
  endfunction

  // ****************************************************************
  // Start detector on the data line's falling edge
  // ****************************************************************
  // Clocked by the line itself so it works with the core clock stopped
  always_comb begin
    l_next = l_reg;
    if (serial_clock_pin && is_two_wire(cfg.wire_mode)) begin
      l_next.start_tgl = ~l_reg.start_tgl; // [RQ15]
    end
  end

  always_ff @(negedge start_line_clk or posedge rst) begin
    if (rst) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // ****************************************************************
  // Core domain
  // ****************************************************************
  logic ext;
  logic soft_ext;
  logic pin_rise;
  logic pin_fall;
  logic ev_rise;
  logic ev_fall;
  logic int_tick;
  logic sample;
  logic change;
  logic count;
  logic ovf_set;
  logic start_ev;
  logic two_wire;
  logic scl_force;

  always_comb begin
    s_next   = s_reg;
    two_wire = is_two_wire(cfg.wire_mode);
    ext      = cfg.clock_source_external;
    soft_ext = ext && cfg.clock_strobe_select;

    // Plain two-stage synchronisers, no filtering in any mode [RQ11]
    s_next.sck_sync = {s_reg.sck_sync[0], serial_clock_pin};
    s_next.din_sync = {s_reg.din_sync[0], serial_data_in};
    s_next.tgl_sync = {s_reg.tgl_sync[1:0], l_reg.start_tgl};
    s_next.sck_prev = s_reg.sck_sync[1];
    s_next.sck_warm = {s_reg.sck_warm[1:0], 1'b1};

    // Edge detect needs two core cycles per half period: clk/4 at most [RQ9]
    // No edge until a real pin level has passed the synchroniser after reset
    pin_rise = s_reg.sck_warm[2] && s_reg.sck_sync[1] && !s_reg.sck_prev;
    pin_fall = s_reg.sck_warm[2] && !s_reg.sck_sync[1] && s_reg.sck_prev;

    // Toggle strobe always inverts the pin driver level
    if (wr.clock_toggle_strobe) begin
      s_next.sck_port = ~s_reg.sck_port; // [RQ10]
    end

    if (soft_ext) begin
      ev_rise = wr.clock_toggle_strobe && !s_reg.sck_port; // [RQ10]
      ev_fall = wr.clock_toggle_strobe && s_reg.sck_port;
    end else if (ext) begin
      ev_rise = pin_rise;
      ev_fall = pin_fall;
    end else begin
      ev_rise = 1'b0;
      ev_fall = 1'b0;
    end

    int_tick = !ext && (cfg.ext_clock_edge_select ? wr.timer_match : wr.soft_clock_strobe);

    // Two-wire use expects edge select clear: capture on rising SCL [RQ13] [RQ18]
    if (ext) begin
      sample = cfg.ext_clock_edge_select ? ev_fall : ev_rise; // [RQ1] [RQ2]
      change = cfg.ext_clock_edge_select ? ev_rise : ev_fall; // [RQ1] [RQ2]
      count  = ev_rise || ev_fall; // [RQ5]
    end else begin
      sample = int_tick;
      change = 1'b0;
      count  = int_tick;
    end

    // A written value wins over a shift in the same cycle
    if (wr.data_write) begin
      s_next.sreg = wr.data_wdata;
    end else if (sample) begin
      s_next.sreg = {s_reg.sreg[`USSU_MSB-1:0], s_reg.din_sync[1]}; // [RQ3]
    end

    ovf_set = 1'b0;
    if (wr.counter_write) begin
      s_next.cnt = wr.counter_wdata;
    end else if (count) begin
      s_next.cnt = 4'(s_reg.cnt + `USSU_CNT_ONE); // [RQ5]
      ovf_set    = (s_reg.cnt == `USSU_CNT_MAX); // [RQ6] [RQ19]
    end

    // Set wins over clear on both flags
    s_next.ovf_flag = ovf_set || (s_reg.ovf_flag && !wr.ovf_clear); // [RQ6] [RQ23]

    start_ev          = (s_reg.tgl_sync[2] != s_reg.tgl_sync[1]) && two_wire;
    s_next.start_flag = start_ev || (s_reg.start_flag && !wr.start_clear); // [RQ15] [RQ24]

    // Output latch stays open with internal clock; external: opens at the change edge, closes at the sampling edge
    if (!ext) begin
      s_next.latch_open = 1'b1; // [RQ25]
    end else if (change) begin
      s_next.latch_open = 1'b1;
    end else if (sample) begin
      s_next.latch_open = 1'b0;
    end
    if (s_next.latch_open) begin
      s_next.do_latch = s_next.sreg[`USSU_MSB]; // [RQ25] [RQ4]
    end

    // Start hold: arm on start, grip once master has pulled the clock low
    unique case (s_reg.hold_st)
      USSU_HOLD_IDLE: begin
        if (start_ev) begin
          s_next.hold_st = USSU_HOLD_ARMED;
        end
      end
      USSU_HOLD_ARMED: begin
        if (wr.start_clear && !start_ev) begin
          s_next.hold_st = USSU_HOLD_IDLE; // [RQ24]
        end else if (!s_reg.sck_sync[1]) begin
          s_next.hold_st = USSU_HOLD_LOW; // [RQ17]
        end
      end
      USSU_HOLD_LOW: begin
        if (wr.start_clear && !start_ev) begin
          s_next.hold_st = USSU_HOLD_IDLE; // [RQ17] [RQ24]
        end
      end
      default: begin
        s_next.hold_st = USSU_HOLD_IDLE;
      end
    endcase
    if (!two_wire) begin
      s_next.hold_st = USSU_HOLD_IDLE;
    end

    // Only this slave side holds the clock; overflow hold in holding mode only [RQ12]
    scl_force = (s_next.hold_st == USSU_HOLD_LOW) ||
                (s_next.ovf_flag && (cfg.wire_mode == `USSU_WM_TWO_HOLD)); // [RQ19] [RQ23]

    s_next.ovf_wake  = s_next.ovf_flag && cfg.ovf_enable; // [RQ7]
    s_next.start_irq = s_next.start_flag && cfg.start_enable; // [RQ15]

    // Pins: open drain in two-wire, push-pull otherwise; unfiltered drive [RQ11]
    if (two_wire) begin
      s_next.sck_out_reg = 1'b0;
      s_next.sck_oe_reg  = scl_force || (cfg.clock_dir && !s_next.sck_port);
      s_next.do_out_reg  = 1'b0;
      s_next.do_oe_reg   = cfg.data_dir && (!s_next.do_latch || !cfg.port_data); // [RQ16]
    end else begin
      s_next.sck_out_reg = s_next.sck_port;
      s_next.sck_oe_reg  = cfg.clock_dir;
      s_next.do_out_reg  = s_next.do_latch;
      s_next.do_oe_reg   = cfg.data_dir && (cfg.wire_mode == `USSU_WM_THREE);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg            <= '0;
      s_reg.sreg       <= `USSU_SREG_RST;
      s_reg.cnt        <= `USSU_CNT_RST;
      s_reg.latch_open <= 1'b1;
      s_reg.hold_st    <= USSU_HOLD_IDLE;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign serial_clock_out = s_reg.sck_out_reg;
  assign serial_clock_oe  = s_reg.sck_oe_reg;
  assign data_out         = s_reg.do_out_reg;
  assign data_oe          = s_reg.do_oe_reg;
  assign stat = {s_reg.sreg, s_reg.cnt, s_reg.ovf_flag,
                 s_reg.start_flag, s_reg.ovf_wake, s_reg.start_irq};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rise_sample_s;
    ce && ext && !cfg.ext_clock_edge_select && ev_rise && !wr.data_write;
  endsequence

  sequence fall_sample_s;
    ce && ext && cfg.ext_clock_edge_select && ev_fall && !wr.data_write;
  endsequence

  sequence start_seen_s;
    ce && start_ev;
  endsequence

  sequence grip_s;
    ce && (s_reg.hold_st == USSU_HOLD_ARMED) && !s_reg.sck_sync[1] &&
      !wr.start_clear && is_two_wire(cfg.wire_mode);
  endsequence

  cap_rise_a: assert property (rise_sample_s |=> // [RQ1]
    s_reg.sreg == {$past(s_reg.sreg[`USSU_MSB-1:0]), $past(s_reg.din_sync[1])})
    else $error("rising edge did not capture input");

  cap_fall_a: assert property (fall_sample_s |=> // [RQ2]
    s_reg.sreg == {$past(s_reg.sreg[`USSU_MSB-1:0]), $past(s_reg.din_sync[1])})
    else $error("falling edge did not capture input");

  count_edges_a: assert property ( // [RQ5]
    ce && ext && (ev_rise || ev_fall) && !wr.counter_write |=>
    s_reg.cnt == 4'($past(s_reg.cnt) + `USSU_CNT_ONE))
    else $error("counter missed a clock edge");

  ovf_set_a: assert property ( // [RQ6]
    ce && count && !wr.counter_write && (s_reg.cnt == `USSU_CNT_MAX) |=>
    s_reg.ovf_flag && (s_reg.cnt == `USSU_CNT_RST))
    else $error("overflow not flagged at wrap");

  idle_wake_a: assert property ( // [RQ7]
    ce && s_next.ovf_flag && cfg.ovf_enable |=> s_reg.ovf_wake)
    else $error("enabled overflow gave no wake");

  strobe_toggle_a: assert property ( // [RQ10]
    ce && wr.clock_toggle_strobe && soft_ext && !wr.counter_write |=>
    (s_reg.sck_port != $past(s_reg.sck_port)) &&
    (s_reg.cnt == 4'($past(s_reg.cnt) + `USSU_CNT_ONE)))
    else $error("toggle strobe did not invert and count");

  start_flag_a: assert property (start_seen_s |=> s_reg.start_flag) // [RQ15]
    else $error("start condition not flagged");

  start_grip_a: assert property (grip_s |=> s_reg.sck_oe_reg [*2]) // [RQ17]
    else $error("clock not held after start");

  ovf_release_a: assert property ( // [RQ23]
    ce && wr.ovf_clear && !ovf_set && (s_next.hold_st != USSU_HOLD_LOW) &&
    !cfg.clock_dir && is_two_wire(cfg.wire_mode) |=>
    !s_reg.ovf_flag && !s_reg.sck_oe_reg)
    else $error("overflow clear did not release clock");

  latch_open_a: assert property ( // [RQ25]
    ce && !ext |=> s_reg.do_latch == s_reg.sreg[`USSU_MSB])
    else $error("internal clock latch not transparent");

endmodule

//--- sim/tb_universal_serial_shift_unit.sv
`timescale 1ns/1ps
module tb_universal_serial_shift_unit;
  import ussu_pkg::*;
  logic        clk = 1'b0;
  logic        lclk = 1'b0;
  logic        rst = 1'b0;
  logic        ce = 1'b1;
  ussu_cfg_s   cfg = '0;
  ussu_wr_s    wr = '0;
  ussu_wr_s    w;
  ussu_stat_s  stat;
  logic        sco, scoe, dout, doe, m_sck, m_sda, scl_wire, sda_wire, ovf_q;
  logic [7:0]  rnd = 8'h57;
  logic [7:0]  rx, dv, e;
  logic [11:0] exp_q[$];
  int          n;
  int          miscompares = 0;
  int          n_checks = 0;

  always #12.5 clk = ~clk;
  always #32 lclk = ~lclk;
  // Open-drain wires in two-wire mode, plain drive in three-wire mode
  assign scl_wire = scoe ? (sco & ~cfg.wire_mode[1]) : m_sck;
  assign sda_wire = (doe & cfg.wire_mode[1]) ? 1'b0 : m_sda;

  ussu_top i_ussu_top (
    .clk              (clk),
    .rst              (rst),
    .ce               (ce),
    .start_line_clk   (sda_wire),
    .cfg              (cfg),
    .wr               (wr),
    .serial_clock_pin (scl_wire),
    .serial_data_in   (sda_wire),
    .serial_clock_out (sco),
    .serial_clock_oe  (scoe),
    .data_out         (dout),
    .data_oe          (doe),
    .stat             (stat)
  );

  ussu_far_master i_ussu_far_master (
    .lclk   (lclk),
    .scl_in (scl_wire),
    .so     (dout),
    .sck    (m_sck),
    .sda    (m_sda)
  );

  // ****
  // Helpers
  // ****
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic fire(input ussu_wr_s v);
    @(negedge clk);
    wr = v;
    @(negedge clk);
    wr = '0;
    @(negedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Each completed byte is matched against the oldest note, clear of the update edge
  always @(negedge clk) begin
    if (stat.count_overflow_flag === 1'b1 && ovf_q !== 1'b1) begin
      if (exp_q.size() == 0) check(16'hFFFF, 16'h0000);
      else check({stat.serial_shift_register, stat.counter_value}, exp_q.pop_front());
    end
    ovf_q <= stat.count_overflow_flag;
  end

  initial begin
    #400us;
    miscompares++;
    summarize();
  end

  // ****
  // Scenarios
  // ****
  initial begin
    // A real edge on reset, so the detector on the data line is cleared too
    #1;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check(stat, 16'h0000);
    cfg.wire_mode = 2'h1;
    cfg.data_dir = 1'b1;
    for (int k = 0; k < 2; k++) begin
      w = '0;
      w.data_write = 1'b1;
      w.data_wdata = k[0] ? 8'hA5 : 8'h5A;
      fire(w);
      check({doe, dout}, {1'b1, k[0]});
      // Internal clocking: soft strobe, then timer match with edge select set
      e = w.data_wdata;
      cfg.ext_clock_edge_select = k[0];
      w = '0;
      w.soft_clock_strobe = !k[0];
      w.timer_match = k[0];
      fire(w);
      check(stat[15:4], {e[6:0], sda_wire, 4'(k + 1)});
    end
    cfg.clock_source_external = 1'b1;
    cfg.ovf_enable = 1'b1;
    for (int m = 0; m < 2; m++) begin
      cfg.ext_clock_edge_select = m[0];
      rnd = lfsr(rnd);
      dv = rnd;
      w = '0;
      w.data_write = 1'b1;
      w.data_wdata = dv;
      w.counter_write = 1'b1;
      fire(w);
      rnd = lfsr(rnd);
      exp_q.push_back({rnd, 4'h0});
      i_ussu_far_master.xfer(m[0], rnd, rx);
      repeat (6) @(negedge clk);
      check(rx, dv);
      check(stat.ovf_wake, 1'b1);
      w = '0;
      w.ovf_clear = 1'b1;
      fire(w);
      check(stat.count_overflow_flag, 1'b0);
    end
    // Software strobe clocking, full byte then preset near overflow
    cfg.clock_strobe_select = 1'b1;
    cfg.ext_clock_edge_select = 1'b0;
    cfg.clock_dir = 1'b1;
    for (int p = 0; p < 2; p++) begin
      n = p ? 2 : 16;
      rnd = lfsr(rnd);
      e = rnd;
      repeat (n / 2) e = {e[6:0], sda_wire};
      exp_q.push_back({e, 4'h0});
      w = '0;
      w.data_write = 1'b1;
      w.data_wdata = rnd;
      w.counter_write = 1'b1;
      w.counter_wdata = p ? 4'hE : 4'h0;
      fire(w);
      w = '0;
      w.clock_toggle_strobe = 1'b1;
      for (int k = 0; k < n; k++) begin
        fire(w);
        if (k == 0) check(sco, 1'b1);
      end
      repeat (2) @(negedge clk);
      w = '0;
      w.ovf_clear = 1'b1;
      fire(w);
    end
    // Two-wire slave: start hold, address byte, overflow hold
    cfg = '0;
    cfg.wire_mode = 2'h3;
    cfg.clock_source_external = 1'b1;
    cfg.start_enable = 1'b1;
    cfg.port_data = 1'b1;
    i_ussu_far_master.start_cond();
    repeat (8) @(negedge clk);
    check({stat.start_detect_flag, stat.start_irq, scoe}, 3'h7);
    rnd = lfsr(rnd);
    exp_q.push_back({rnd, 4'h0});
    fork
      i_ussu_far_master.xfer(1'b0, rnd, rx);
      begin
        repeat (20) @(negedge clk);
        check(scl_wire, 1'b0);
        w = '0;
        w.start_clear = 1'b1;
        w.counter_write = 1'b1;
        fire(w);
        check({stat.start_detect_flag, scoe}, 2'h0);
      end
    join
    repeat (6) @(negedge clk);
    check(scoe, 1'b1);
    w = '0;
    w.ovf_clear = 1'b1;
    fire(w);
    check(scoe, 1'b0);
    // Slave pulls SDA for a low MSB; a set MSB leaves it released, as for a withheld ack
    cfg.data_dir = 1'b1;
    for (int k = 0; k < 2; k++) begin
      w = '0;
      w.data_write = 1'b1;
      w.data_wdata = {k[0], 7'h00};
      fire(w);
      check({doe, doe & sda_wire}, {!k[0], 1'b0});
    end
    check(16'(exp_q.size()), 16'h0000);
    summarize();
  end
endmodule

//--- sim/ussu_far_master.sv
`timescale 1ns/1ps
// ****
// Far-side serial master, paced by the link clock
// ****
module ussu_far_master (
  input  wire logic lclk,
  input  wire logic scl_in,
  input  wire logic so,
  output logic      sck,
  output logic      sda
);
  initial begin
    sck = 1'b0;
    sda = 1'b1;
  end

  // A release may be stretched by the slave, so wait for the wire
  task automatic edge_to(input logic lvl);
    int n;
    n = 0;
    @(posedge lclk);
    sck = lvl;
    while (scl_in !== lvl && n < 400) begin
      @(posedge lclk);
      n++;
    end
  endtask

  // MSB first; data settles two and a half link periods ahead of the sampling edge
  task automatic xfer(input logic m1, input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (m1) edge_to(~sck);
      // Data moves half a link period after the clock, never with it
      @(negedge lclk);
      sda = tx[i];
      repeat (2) @(posedge lclk);
      edge_to(~sck);
      rx[i] = so;
      repeat (2) @(posedge lclk);
      if (!m1) edge_to(~sck);
    end
    // Hold time over: line no longer shows the last bit
    @(negedge lclk);
    sda = ~tx[0];
  endtask

  task automatic start_cond();
    sda = 1'b1;
    edge_to(1'b1);
    repeat (2) @(posedge lclk);
    sda = 1'b0;
    repeat (2) @(posedge lclk);
    sck = 1'b0;
  endtask
endmodule
